/* mss_defines.svh */
// mss_defines.svh: timing counts, display codes and contact input indices for the motor start/stop sequencer
// assumes nothing of its surroundings; definitions only
`ifndef MSS_DEFINES_SVH
`define MSS_DEFINES_SVH

`define MSS_CLK_HZ          200000000
`define MSS_TICK_CYCLES     (`MSS_CLK_HZ)
`define MSS_DEBOUNCE_MS     10
`define MSS_DEBOUNCE_CYCLES ((`MSS_CLK_HZ / 1000) * `MSS_DEBOUNCE_MS)
`define MSS_TIMER_W         9
`define MSS_SEL_W           2

// display codes, one nibble per digit, digit 3 leftmost
`define MSS_DISP_IDLE       16'h0000
`define MSS_DISP_EXT_TRIP   16'hE7A1
`define MSS_DISP_FLOW_TO    16'h72DF
`define MSS_DISP_RECORD     16'hFEC0

`define MSS_IN_W            7
`define MSS_IN_ON           0
`define MSS_IN_OFF          1
`define MSS_IN_FLOW         2
`define MSS_IN_TRIP1        3
`define MSS_IN_TRIP2        4
`define MSS_IN_RESET        5
`define MSS_IN_FEEDBACK     6

`endif

/* mss_pkg.sv */
// mss_pkg.sv: types shared by the sequencer modules
// assumes mss_defines.svh is on the include path
`include "mss_defines.svh"
package mss_pkg;
    typedef enum logic [2:0] {
        MSS_IDLE,
        MSS_ON_WAIT,
        MSS_RUN,
        MSS_OFF_WAIT,
        MSS_FLOW_LOST,
        MSS_FLOW_TIMEOUT,
        MSS_TRIPPED
    } mss_state_e;

    typedef enum logic [2:0] {
        MSS_START_DIRECT,
        MSS_START_STAR_DELTA,
        MSS_START_REVERSE,
        MSS_START_REACTOR,
        MSS_START_INVERTER
    } mss_start_e;

    typedef enum logic [1:0] {
        MSS_SRC_LOCAL,
        MSS_SRC_AUTO,
        MSS_SRC_WATER
    } mss_src_e;
endpackage

/* mss_in_if.sv */
// mss_in_if.sv: cleaned contact levels and their one-cycle rising/falling pulses
// assumes producer and consumer share clk_sys
`timescale 1ns/1ps
`default_nettype none
`include "mss_defines.svh"
interface mss_in_if #(
    parameter int N = `MSS_IN_W
);
    logic [N-1:0] level;
    logic [N-1:0] rise;
    logic [N-1:0] fall;
    modport producer (output level, output rise, output fall);
    modport consumer (input level, input rise, input fall);
endinterface
`default_nettype wire

/* mss_debounce.sv */
// mss_debounce.sv: synchronises and debounces every contact input
// assumes raw contacts are asynchronous to clk_sys
`timescale 1ns/1ps
`default_nettype none
`include "mss_defines.svh"
module mss_debounce
    import mss_pkg::*;
#(
    parameter int N      = `MSS_IN_W,
    parameter int CYCLES = `MSS_DEBOUNCE_CYCLES
) (
    input  wire logic         clk_sys,
    input  wire logic         rst_n,
    input  wire logic [N-1:0] raw,
    mss_in_if.producer        cln
);
    localparam int CW = $clog2(CYCLES + 1);

    typedef struct packed {
        logic [N-1:0] s1;
        logic [N-1:0] s2;
        logic [N-1:0] level;
        logic [N-1:0] rise;
        logic [N-1:0] fall;
        logic [N-1:0][CW-1:0] cnt;
    } mss_deb_s;

    mss_deb_s r;
    mss_deb_s next_r;

    always_comb begin
        next_r      = r;
        next_r.s1   = raw;
        next_r.s2   = r.s1;
        next_r.rise = '0;
        next_r.fall = '0;
        // a level is accepted only after it held steady for the full window
        for (int i = 0; i < N; i++) begin
            if (r.s2[i] == r.level[i]) begin
                next_r.cnt[i] = '0;
            end else if (r.cnt[i] == CW'(CYCLES - 1)) begin
                next_r.cnt[i]   = '0;
                next_r.level[i] = r.s2[i];
                next_r.rise[i]  = r.s2[i];
                next_r.fall[i]  = ~r.s2[i];
            end else begin
                next_r.cnt[i] = r.cnt[i] + CW'(1);
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign cln.level = r.level;
    assign cln.rise  = r.rise;
    assign cln.fall  = r.fall;
endmodule
`default_nettype wire

/* mss_sequencer.sv */
// mss_sequencer.sv: motor start/stop sequencer top, contactor, trips, status and display
// assumes contacts are raw pins; settings are static levels from the setting logic
// Overview of operation
// - time-delay mode: after ON, wait ON delay, then close main contactor.
// - time-delay mode: after OFF, wait OFF delay, then open main contactor.
// - second external trip: assert fault, drop contactor, show external-trip code.
// - trip releases only once trip input is removed and reset then applied.
// - flow mode: flow within comparison window starts motor after ON delay.
// - flow mode: no flow in start window cancels ON, shows flow-timeout code.
// - flow mode while running: flow loss drops contactor immediately.
// - after flow loss, flow back within window restarts after ON delay.
// - flow absent through the window: show flow-timeout code, stay off.
// - flow mode: OFF opens contactor after the OFF delay.
// - up/down steps phase fault currents; escape plus enter opens fault record.
// - three status outputs show local, automatic or water-level source.
// - three operating outputs follow the configured start type.
// - contactor feedback is monitored and lights a panel indicator.
`timescale 1ns/1ps
`default_nettype none
`include "mss_defines.svh"
module mss_sequencer
    import mss_pkg::*;
#(
    parameter int TICK_CYCLES     = `MSS_TICK_CYCLES,
    parameter int DEBOUNCE_CYCLES = `MSS_DEBOUNCE_CYCLES,
    parameter int TW              = `MSS_TIMER_W
) (
    input  wire logic          clk_sys,
    input  wire logic          rst_n,
    input  wire logic          on_cmd,
    input  wire logic          off_cmd,
    input  wire logic          flow_switch,
    input  wire logic          ext_trip1,
    input  wire logic          ext_trip2,
    input  wire logic          reset_button,
    input  wire logic          contactor_feedback,
    input  wire logic          flow_mode,
    input  wire logic [TW-1:0] on_delay_timer,
    input  wire logic [TW-1:0] off_delay_timer,
    input  wire logic [TW-1:0] comparison_timer,
    input  wire mss_start_e    start_type,
    input  wire mss_src_e      control_source,
    input  wire logic          up_button,
    input  wire logic          down_button,
    input  wire logic          escape_button,
    input  wire logic          enter_button,
    input  wire logic [15:0]   phase_current,
    output logic               main_contactor_output,
    output logic               fault_output,
    output logic [2:0]         status_output,
    output logic [2:0]         operating_output,
    output logic               feedback_led,
    output logic               on_delay_active,
    output logic               off_delay_active,
    output logic [15:0]        display
);
    typedef struct packed {
        mss_state_e     st;
        logic [31:0]    tick_cnt;
        logic [TW-1:0]  sec;
        logic [TW-1:0]  cmp;
        logic           flow_to;
        logic [1:0]     sel;
        logic           rec;
        logic [3:0]     btn_q;
        logic [2:0][15:0] fault_cur;
        logic [15:0]    disp;
        logic           contactor;
        logic [2:0]     oper;
        logic [2:0]     stat;
    } mss_top_s;

    mss_top_s r;
    mss_top_s next_r;
    logic     rst_sync_n;
    logic     tick;
    logic [3:0] btn_raw;

    mss_in_if #(.N(`MSS_IN_W + 4)) cln ();

    // buttons share the debouncer so their strobes stay clean too
    mss_debounce #(
        .N      (`MSS_IN_W + 4),
        .CYCLES (DEBOUNCE_CYCLES)
    ) u_deb (
        .clk_sys (clk_sys),
        .rst_n   (rst_sync_n),
        .raw     ({btn_raw, contactor_feedback, reset_button, ext_trip2, ext_trip1,
                   flow_switch, off_cmd, on_cmd}),
        .cln     (cln)
    );
    assign btn_raw = {enter_button, escape_button, down_button, up_button};

    // the reset pair alone lives outside the state struct: it must not reset with itself
    logic [1:0] rs_q;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rs_q <= 2'h0;
        end else begin
            rs_q <= {rs_q[0], 1'b1};
        end
    end
    assign rst_sync_n = rs_q[1];

    function automatic logic [2:0] mss_oper(input mss_start_e t, input logic run);
        unique case (t)
            MSS_START_DIRECT:     mss_oper = {2'h0, run};
            MSS_START_STAR_DELTA: mss_oper = {1'b0, run, run};
            MSS_START_REVERSE:    mss_oper = {1'b0, run, 1'b0};
            MSS_START_REACTOR:    mss_oper = {run, 1'b0, run};
            MSS_START_INVERTER:   mss_oper = {run, 2'h0};
            default:              mss_oper = 3'h0;
        endcase
    endfunction

    logic on_ev;
    logic off_ev;
    logic flow;
    logic trip;
    logic [3:0] btn;
    assign on_ev  = cln.rise[`MSS_IN_ON];
    assign off_ev = cln.rise[`MSS_IN_OFF];
    assign flow   = cln.level[`MSS_IN_FLOW];
    assign trip   = cln.level[`MSS_IN_TRIP1] | cln.level[`MSS_IN_TRIP2];
    assign btn    = cln.level[`MSS_IN_W+3:`MSS_IN_W];
    assign tick   = (r.tick_cnt == 32'(TICK_CYCLES - 1));

    always_comb begin
        next_r          = r;
        next_r.btn_q    = btn;
        next_r.tick_cnt = tick ? 32'h0 : r.tick_cnt + 32'h1;
        if (tick && r.sec != '0) begin
            next_r.sec = r.sec - TW'(1);
        end
        if (tick && r.cmp != '0) begin
            next_r.cmp = r.cmp - TW'(1);
        end
        unique case (r.st)
            MSS_IDLE, MSS_FLOW_TIMEOUT: begin
                if (on_ev) begin
                    next_r.st      = MSS_ON_WAIT;
                    next_r.sec     = on_delay_timer;
                    // restarting the tick keeps the first counted second whole
                    next_r.tick_cnt = 32'h0;
                    next_r.cmp     = comparison_timer;
                    next_r.flow_to = 1'b0;
                end
            end
            MSS_ON_WAIT: begin
                if (off_ev) begin
                    next_r.st = MSS_IDLE;
                end else if (flow_mode && !flow && r.cmp == '0) begin
                    next_r.st      = MSS_FLOW_TIMEOUT;
                    next_r.flow_to = 1'b1;
                end else if (r.sec == '0 && (!flow_mode || flow)) begin
                    next_r.st        = MSS_RUN;
                    next_r.contactor = 1'b1;
                end
            end
            MSS_RUN: begin
                if (flow_mode && !flow) begin
                    next_r.contactor = 1'b0;
                    next_r.st        = MSS_FLOW_LOST;
                    next_r.sec       = on_delay_timer;
                    next_r.tick_cnt  = 32'h0;
                    next_r.cmp       = comparison_timer;
                end else if (off_ev) begin
                    next_r.st  = MSS_OFF_WAIT;
                    next_r.sec = off_delay_timer;
                    next_r.tick_cnt = 32'h0;
                end
            end
            MSS_OFF_WAIT: begin
                if (on_ev) begin
                    next_r.st = MSS_RUN;
                end else if (r.sec == '0) begin
                    next_r.st        = MSS_IDLE;
                    next_r.contactor = 1'b0;
                end
            end
            MSS_FLOW_LOST: begin
                // flow must return while cmp still exceeds the ON delay
                if (off_ev) begin
                    next_r.st = MSS_IDLE;
                end else if (flow && r.cmp > on_delay_timer) begin
                    next_r.st  = MSS_ON_WAIT;
                    next_r.sec = on_delay_timer;
                    next_r.tick_cnt = 32'h0;
                end else if (r.cmp <= on_delay_timer) begin
                    next_r.st      = MSS_FLOW_TIMEOUT;
                    next_r.flow_to = 1'b1;
                end
            end
            MSS_TRIPPED: begin
                if (!trip && cln.rise[`MSS_IN_RESET]) begin
                    next_r.st = MSS_IDLE;
                end
            end
            default: next_r.st = MSS_IDLE;
        endcase
        if (trip) begin
            next_r.st        = MSS_TRIPPED;
            next_r.contactor = 1'b0;
        end
        if (next_r.st != MSS_TRIPPED && r.st != MSS_TRIPPED) begin
            next_r.fault_cur = {phase_current, r.fault_cur[2:1]};
        end
        // fault record view
        if (btn[2] && btn[3]) begin
            next_r.rec = 1'b1;
        end else if (btn[0] & ~r.btn_q[0]) begin
            next_r.rec = 1'b0;
            next_r.sel = (r.sel == 2'h2) ? 2'h0 : r.sel + 2'h1;
        end else if (btn[1] & ~r.btn_q[1]) begin
            next_r.rec = 1'b0;
            next_r.sel = (r.sel == 2'h0) ? 2'h2 : r.sel - 2'h1;
        end
        if (next_r.st == MSS_TRIPPED && cln.level[`MSS_IN_TRIP2]) begin
            next_r.disp = `MSS_DISP_EXT_TRIP;
        end else if (next_r.flow_to) begin
            next_r.disp = `MSS_DISP_FLOW_TO;
        end else if (r.rec) begin
            next_r.disp = `MSS_DISP_RECORD;
        end else begin
            next_r.disp = r.fault_cur[r.sel];
        end
        next_r.oper = mss_oper(start_type, next_r.contactor);
        unique case (control_source)
            MSS_SRC_LOCAL: next_r.stat = 3'h1;
            MSS_SRC_AUTO:  next_r.stat = 3'h2;
            MSS_SRC_WATER: next_r.stat = 3'h4;
            default:       next_r.stat = 3'h0;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            r    <= '0;
            r.st <= MSS_IDLE;
        end else begin
            r <= next_r;
        end
    end

    assign main_contactor_output = r.contactor;
    assign fault_output          = (r.st == MSS_TRIPPED);
    assign status_output         = r.stat;
    assign operating_output      = r.oper;
    assign feedback_led          = cln.level[`MSS_IN_FEEDBACK];
    assign on_delay_active       = (r.st == MSS_ON_WAIT);
    assign off_delay_active      = (r.st == MSS_OFF_WAIT);
    assign display               = r.disp;
endmodule
`default_nettype wire

/* mss_contactor_model.sv */
// mss_contactor_model.sv: motor contactor whose auxiliary contact follows the coil
// assumes the coil is driven synchronously to clk_sys
`timescale 1ns/1ps
`default_nettype none
module mss_contactor_model (
    input  wire logic clk_sys,
    input  wire logic coil,
    output logic      aux_contact
);
    logic [2:0] arm = 3'h0;
    // the armature takes a few cycles to pull in or drop out, so the led path sees a real lag
    always @(posedge clk_sys) begin
        arm <= {arm[1:0], coil};
    end
    assign aux_contact = arm[2];
endmodule
`default_nettype wire

/* mss_sequencer_assertions.sv */
// mss_sequencer_assertions.sv: port-level checks on the sequencer, bound to its top
// assumes mss_pkg and mss_defines.svh are compiled first
`timescale 1ns/1ps
`default_nettype none
`include "mss_defines.svh"
module mss_sequencer_assertions
    import mss_pkg::*;
(
    input wire logic        clk_sys,
    input wire logic        rst_n,
    input wire logic        flow_switch,
    input wire logic        flow_mode,
    input wire logic        ext_trip1,
    input wire logic        ext_trip2,
    input wire logic        contactor_feedback,
    input wire mss_src_e    control_source,
    input wire logic        main_contactor_output,
    input wire logic        fault_output,
    input wire logic [2:0]  status_output,
    input wire logic [2:0]  operating_output,
    input wire logic        feedback_led,
    input wire logic        on_delay_active,
    input wire logic        off_delay_active,
    input wire logic [15:0] display
);
    logic [2:0] up_cnt;
    logic       armed;
    assign armed = (up_cnt == 3'h7);
    // outputs settle only a few edges after the internal reset copy lets go
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            up_cnt <= 3'h0;
        end else if (!armed) begin
            up_cnt <= up_cnt + 3'h1;
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    sequence trip2_held_s;
        ext_trip2 [*8];
    endsequence
    sequence flow_gone_s;
        (flow_mode && !flow_switch) [*8];
    endsequence
    chk_start_after_wait: assert property ($rose(main_contactor_output) |-> $past(on_delay_active))
        else $error("contactor closed without an on wait");
    chk_stop_after_wait: assert property ($fell(main_contactor_output) && !fault_output && !flow_mode
        |-> $past(off_delay_active)) else $error("contactor opened without an off wait");
    chk_trip_drops_coil: assert property (fault_output |-> !main_contactor_output)
        else $error("contactor closed while tripped");
    chk_trip_raises_fault: assert property (trip2_held_s |-> ##[0:6] fault_output)
        else $error("trip input not followed by fault");
    chk_trip_code_shown: assert property ($rose(fault_output) && ext_trip2
        |-> ##[0:2] display == `MSS_DISP_EXT_TRIP) else $error("trip code not shown");
    chk_release_needs_clear: assert property ($fell(fault_output) |-> !ext_trip1 && !ext_trip2)
        else $error("fault released with trip still present");
    chk_flow_loss_drop: assert property (flow_gone_s |-> ##[0:4] !main_contactor_output)
        else $error("contactor held without flow");
    chk_status_source: assert property (armed && $stable(control_source)
        |=> status_output == (3'h1 << $past(control_source))) else $error("status does not match source");
    chk_operating_gated: assert property (armed && !main_contactor_output |-> operating_output == 3'h0)
        else $error("operating outputs active with contactor open");
    chk_led_follows_aux: assert property ($rose(feedback_led)
        |-> contactor_feedback && $past(contactor_feedback, 3)) else $error("led lit without feedback");
endmodule
bind mss_sequencer mss_sequencer_assertions u_chk (
    .clk_sys(clk_sys), .rst_n(rst_n), .flow_switch(flow_switch), .flow_mode(flow_mode),
    .ext_trip1(ext_trip1), .ext_trip2(ext_trip2), .contactor_feedback(contactor_feedback),
    .control_source(control_source), .main_contactor_output(main_contactor_output),
    .fault_output(fault_output), .status_output(status_output), .operating_output(operating_output),
    .feedback_led(feedback_led), .on_delay_active(on_delay_active), .off_delay_active(off_delay_active),
    .display(display));
`default_nettype wire

/* motor_start_stop_sequencer_bench.sv */
// motor_start_stop_sequencer_bench.sv: self-checking bench for the sequencer
// assumes short tick and debounce counts; ON and OFF delays 2 s, comparison 5 s
`timescale 1ns/1ps
`default_nettype none
`include "mss_defines.svh"
module motor_start_stop_sequencer_bench;
    import mss_pkg::*;
    typedef struct packed { logic fm; logic flow; logic exp_on; } mss_row_s;
    mss_row_s    rows [3] = '{3'h1, 3'h7, 3'h4};
    logic        clk_sys = 1'h0, rst_n = 1'h0, flow = 1'h0, trip1 = 1'h0, trip2 = 1'h0, fm = 1'h0;
    logic [6:0]  pb = 7'h00;
    mss_src_e    src = MSS_SRC_LOCAL;
    mss_start_e  stt = MSS_START_STAR_DELTA;
    logic [15:0] cur = 16'h1234;
    logic        fb, mc, flt, led, ona, offa;
    logic [2:0]  st, op;
    logic [15:0] disp;
    int          n_fail = 0;
    int          tests_run = 0;
    mss_sequencer #(.TICK_CYCLES(20), .DEBOUNCE_CYCLES(4)) u_dut (
        .clk_sys(clk_sys), .rst_n(rst_n), .on_cmd(pb[0]), .off_cmd(pb[1]), .flow_switch(flow),
        .ext_trip1(trip1), .ext_trip2(trip2), .reset_button(pb[2]), .contactor_feedback(fb),
        .flow_mode(fm), .on_delay_timer(9'h002), .off_delay_timer(9'h002),
        .comparison_timer(9'h005), .start_type(stt), .control_source(src),
        .up_button(pb[3]), .down_button(pb[4]), .escape_button(pb[5]), .enter_button(pb[6]),
        .phase_current(cur), .main_contactor_output(mc), .fault_output(flt), .status_output(st),
        .operating_output(op), .feedback_led(led), .on_delay_active(ona), .off_delay_active(offa),
        .display(disp));
    mss_contactor_model u_plant (.clk_sys(clk_sys), .coil(mc), .aux_contact(fb));
    initial begin
        forever #2.5 clk_sys = ~clk_sys;
    end
    task automatic wt(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    // held long enough to pass the debouncer, then released cleanly
    task automatic press(input int b);
        pb <= 7'h01 << b;
        wt(10);
        pb <= 7'h00;
        wt(10);
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        wt(10);
        chk(mc, 1'h0);
        chk(st, 3'h0);
        wt(10);
        rst_n <= 1'h1;
        wt(4);
        for (int s = 0; s < 3; s++) begin
            src <= mss_src_e'(s);
            wt(4);
            chk(st, 3'h1 << s);
        end
        pb <= 7'h01;
        wt(2);
        pb <= 7'h00;
        wt(15);
        chk(ona, 1'h0);
        $display("test reset and glitch done");
        for (int i = 0; i < 3; i++) begin
            fm <= rows[i].fm;
            stt <= mss_start_e'(i);
            flow <= rows[i].flow;
            wt(12);
            press(0);
            chk(ona, 1'h1);
            chk(mc, 1'h0);
            wt(40);
            chk(mc, rows[i].exp_on);
            if (rows[i].exp_on) begin
                chk(led, 1'h1);
                chk(op != 3'h0, 1'h1);
                press(1);
                chk(offa, 1'h1);
                chk(mc, 1'h1);
                wt(40);
                chk(mc, 1'h0);
                chk(op, 3'h0);
            end else begin
                wt(80);
                chk(disp, `MSS_DISP_FLOW_TO);
                chk(mc, 1'h0);
            end
            $display("test row %0d done", i);
        end
        flow <= 1'h1;
        wt(12);
        press(0);
        wt(40);
        chk(mc, 1'h1);
        flow <= 1'h0;
        wt(15);
        chk(mc, 1'h0);
        flow <= 1'h1;
        wt(80);
        chk(mc, 1'h1);
        flow <= 1'h0;
        wt(160);
        chk(disp, `MSS_DISP_FLOW_TO);
        chk(mc, 1'h0);
        $display("test flow loss done");
        flow <= 1'h1;
        wt(12);
        press(0);
        wt(40);
        trip2 <= 1'h1;
        wt(12);
        chk(flt, 1'h1);
        chk(mc, 1'h0);
        chk(disp, `MSS_DISP_EXT_TRIP);
        press(2);
        chk(flt, 1'h1);
        trip2 <= 1'h0;
        wt(12);
        chk(flt, 1'h1);
        press(2);
        chk(flt, 1'h0);
        trip1 <= 1'h1;
        wt(12);
        chk(flt, 1'h1);
        trip1 <= 1'h0;
        wt(12);
        press(2);
        chk(flt, 1'h0);
        $display("test trips done");
        pb <= 7'h60;
        cur <= 16'hA5C3;
        wt(12);
        chk(disp, `MSS_DISP_RECORD);
        pb <= 7'h00;
        wt(2);
        press(3);
        chk(disp, 16'hA5C3);
        press(4);
        chk(disp, 16'hA5C3);
        $display("test buttons done");
        summarize();
    end
    // the full sequence needs under 2000 cycles
    initial begin
        wt(20000);
        n_fail++;
        $display("watchdog expired");
        summarize();
    end
endmodule
`default_nettype wire
